// file: dv/dacpc_src_model.sv
// Sample source standing in for the audio interface that feeds playback
`timescale 1ns/1ps
module dacpc_src_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic send,
   input wire logic [15:0] l,
   input wire logic [15:0] r,
   output logic in_valid,
   output logic signed [15:0] in_left,
   output logic signed [15:0] in_right
);
   always_ff @(posedge clk) begin
      if (rst) begin
         in_valid <= 1'b0;
         in_left <= 16'h0000;
         in_right <= 16'h0000;
      end else if (send) begin
         in_valid <= 1'b1;
         in_left <= l;
         in_right <= r;
      end else begin
         // Stale data scrambles between samples
         in_valid <= 1'b0;
         in_left <= ~in_left;
         in_right <= ~in_right;
      end
   end
endmodule // dacpc_src_model

// file: dv/tb_top.sv
// Self-checking bench for the playback path control block
`timescale 1ns/1ps
module tb_top;
   logic clk, rst, hsel, hwrite, hready, send, in_valid, out_valid, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0] htrans, s_hl, s_hr, s_ll, s_lr;
   logic [15:0] sl, sr, ol, orr;
   logic signed [15:0] in_left, in_right, out_left, out_right;
   logic lce, rce, osr, hpl, hpr, lnl, lnr;
   logic [15:0] dtab [4];
   int mismatches, tests_run;
   assign hready = hreadyout;

   dacpc_src_model i_src (.clk(clk), .rst(rst), .send(send), .l(sl), .r(sr),
      .in_valid(in_valid), .in_left(in_left), .in_right(in_right));

   dacpc_top #(.W(16)) i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .in_valid(in_valid), .in_left(in_left), .in_right(in_right),
      .out_valid(out_valid), .out_left(out_left), .out_right(out_right),
      .left_converter_enable(lce), .right_converter_enable(rce), .oversample_double_select(osr),
      .left_headphone_amp_enable(hpl), .right_headphone_amp_enable(hpr),
      .left_line_amp_enable(lnl), .right_line_amp_enable(lnr),
      .left_headphone_pin_src(s_hl), .right_headphone_pin_src(s_hr),
      .left_line_pin_src(s_ll), .right_line_pin_src(s_lr));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic tally_and_finish();
      if (mismatches == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, exp, got);
      end
   endtask

   task automatic wt_rdy();
      int i;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (hreadyout !== 1'b1 && i < 50);
      if (i >= 50) begin
         mismatches++;
         tally_and_finish();
      end
   endtask

   task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= wr;
      wt_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wt_rdy();
      v = hrdata;
   endtask

   task automatic rdchk(input string n, input logic [7:0] idx, input logic [31:0] exp);
      bus(idx, 1'b0, 32'h0);
      chk(n, v, exp);
   endtask

   task automatic play(input logic [15:0] l, input logic [15:0] r);
      int i;
      sl <= l;
      sr <= r;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (out_valid !== 1'b1 && i < 20);
      if (i >= 20) begin
         mismatches++;
         tally_and_finish();
      end
      ol = out_left;
      orr = out_right;
   endtask

   task automatic zeros(input int n);
      repeat (n) play(16'h0000, 16'h0000);
   endtask

   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      send = 1'b0;
      sl = 16'h0000;
      sr = 16'h0000;
      mismatches = 0;
      tests_run = 0;
      dtab = '{16'h4000, 16'h2F00, 16'h2B00, 16'h2A00};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rdchk("hp power", dacpc_pkg::IDX_HP_POWER, 32'h0);
      chk("bus response", {hresp, hreadyout}, 32'h1);
      rdchk("line power", dacpc_pkg::IDX_LINE_POWER, 32'h0);
      rdchk("dac ctrl", dacpc_pkg::IDX_DAC_CTRL, 32'h8);
      rdchk("path ctrl", dacpc_pkg::IDX_PATH_CTRL, 32'h0);
      chk("enables", {hpl, hpr, lnl, lnr, lce, rce, osr}, 32'h0);
      chk("pin sources", {s_hl, s_hr, s_ll, s_lr}, 32'h0);
      bus(dacpc_pkg::IDX_DAC_CTRL, 1'b1, 32'hFFFF);
      rdchk("dac ctrl mask", dacpc_pkg::IDX_DAC_CTRL, 32'h1A4E);
      bus(8'h10, 1'b1, 32'hFFFF);
      rdchk("unmapped", 8'h10, 32'h0);
      // Direct writes stand in for the start-up sequence
      for (int k = 1; k < 4; k++) begin
         bus(dacpc_pkg::IDX_HP_POWER, 1'b1, 32'(k));
         bus(dacpc_pkg::IDX_LINE_POWER, 1'b1, 32'(3 - k));
         repeat (2) @(posedge clk);
         chk("hp amps", {hpl, hpr}, 32'(k));
         chk("line amps", {lnl, lnr}, 32'(3 - k));
      end
      bus(dacpc_pkg::IDX_DAC_CTRL, 1'b1, 32'h0);
      bus(dacpc_pkg::IDX_PATH_CTRL, 1'b1, 32'h3);
      zeros(3);
      play(16'h1234, 16'h0567);
      chk("stereo", {ol, orr}, 32'h12340567);
      bus(dacpc_pkg::IDX_DAC_CTRL, 1'b1, 32'h1000);
      play(16'h1000, 16'h0200);
      chk("mono both on", {ol, orr}, 32'h10000200);
      bus(dacpc_pkg::IDX_PATH_CTRL, 1'b1, 32'h2);
      play(16'h1000, 16'h0200);
      chk("mono left", {ol, orr}, 32'h09000000);
      chk("converters", {lce, rce}, 32'h2);
      bus(dacpc_pkg::IDX_PATH_CTRL, 1'b1, 32'h1);
      play(16'h1000, 16'h0200);
      chk("mono right", {ol, orr}, 32'h00000900);
      chk("converters", {lce, rce}, 32'h1);
      bus(dacpc_pkg::IDX_PATH_CTRL, 1'b1, 32'h3);
      for (int k = 0; k < 4; k++) begin
         bus(dacpc_pkg::IDX_DAC_CTRL, 1'b1, 32'(k * 2));
         zeros(10);
         play(16'h4000, 16'h4000);
         chk("deemphasis", {ol, orr}, {dtab[k], dtab[k]});
      end
      // Low sample rate playback picks the sloping response
      bus(dacpc_pkg::IDX_DAC_CTRL, 1'b1, 32'h0800);
      zeros(10);
      play(16'h1000, 16'h1000);
      chk("sloping first", {ol, orr}, 32'h08000800);
      play(16'h1000, 16'h1000);
      chk("sloping second", {ol, orr}, 32'h10001000);
      bus(dacpc_pkg::IDX_DAC_CTRL, 1'b1, 32'h0040);
      play(16'h0000, 16'h0000);
      chk("osr double", osr, 32'h1);
      bus(dacpc_pkg::IDX_DAC_CTRL, 1'b1, 32'h0000);
      play(16'h0000, 16'h0000);
      chk("osr normal", osr, 32'h0);
      bus(dacpc_pkg::IDX_PATH_CTRL, 1'b1, 32'h1A7);
      play(16'h0000, 16'h0000);
      chk("bypass sel", {s_hl, s_hr, s_ll, s_lr}, 32'h69);
      bus(dacpc_pkg::IDX_DAC_CTRL, 1'b1, 32'h0208);
      zeros(140);
      bus(dacpc_pkg::IDX_DAC_CTRL, 1'b1, 32'h0200);
      play(16'h4000, 16'h4000);
      chk("ramp partial", {ol, orr}, 32'h00800080);
      bus(dacpc_pkg::IDX_STATUS, 1'b0, 32'h0);
      chk("ramp state", v[10:0], 32'h401);
      tally_and_finish();
   end
endmodule // tb_top

// file: logic/dacpc_deemphasis_rate_select.sv
// De-emphasis shelf filter for one playback channel
`timescale 1ns/1ps
module dacpc_deemphasis_rate_select #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic signed [W-1:0] in_sample,
   input wire dacpc_pkg::dacpc_deemphasis_rate_select_t rate,
   output logic out_valid,
   output logic signed [W-1:0] out_sample
);
   localparam int AW = W + 18;
   dacpc_pkg::dacpc_coef_t coef;
   logic signed [AW-1:0] acc;
   logic valid_d;
   logic valid_q;
   logic signed [W-1:0] y_d;
   logic signed [W-1:0] y_q;

   always_comb begin
      coef = dacpc_pkg::deemphasis_rate_select_coef(rate);
      acc = AW'(coef.b0 * in_sample) + AW'(coef.a1 * y_q);
      valid_d = in_valid;
      y_d = y_q;
      if (in_valid) begin
         // RULE_05 rate chooses shelf
         if (rate == dacpc_pkg::DACPC_DEEMPHASIS_RATE_SELECT_NONE) begin
            y_d = in_sample;
         end else begin
            y_d = W'(acc >>> dacpc_pkg::COEF_FRAC);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         valid_q <= 1'b0;
         y_q <= '0;
      end else begin
         valid_q <= valid_d;
         y_q <= y_d;
      end
   end

   assign out_valid = valid_q;
   assign out_sample = y_q;
endmodule // dacpc_deemphasis_rate_select

// file: logic/dacpc_interp.sv
// Interpolation filter response select for one playback channel
`timescale 1ns/1ps
module dacpc_interp #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic signed [W-1:0] in_sample,
   input wire logic sloping,
   output logic out_valid,
   output logic signed [W-1:0] out_sample
);
   logic valid_d;
   logic valid_q;
   logic signed [W-1:0] hist_d;
   logic signed [W-1:0] hist_q;
   logic signed [W-1:0] y_d;
   logic signed [W-1:0] y_q;
   logic signed [W:0] pair;

   always_comb begin
      pair = (W+1)'(in_sample) + (W+1)'(hist_q);
      valid_d = in_valid;
      hist_d = hist_q;
      y_d = y_q;
      if (in_valid) begin
         hist_d = in_sample;
         // RULE_06 normal or sloping response
         y_d = sloping ? W'(pair >>> 1) : in_sample;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         valid_q <= 1'b0;
         hist_q <= '0;
         y_q <= '0;
      end else begin
         valid_q <= valid_d;
         hist_q <= hist_d;
         y_q <= y_d;
      end
   end

   assign out_valid = valid_q;
   assign out_sample = y_q;
endmodule // dacpc_interp

// file: logic/dacpc_pkg.sv
// Shared constants, types and coefficient lookup for the playback path control block
package dacpc_pkg;
   localparam logic [7:0] IDX_HP_POWER = 8'h0E;
   localparam logic [7:0] IDX_LINE_POWER = 8'h0F;
   localparam logic [7:0] IDX_DAC_CTRL = 8'h21;
   localparam logic [7:0] IDX_PATH_CTRL = 8'h30;
   localparam logic [7:0] IDX_STATUS = 8'h31;
   localparam int BIT_MONO = 12;
   localparam int BIT_SLOPING = 11;
   localparam int BIT_UNMUTE_RAMP = 9;
   localparam int BIT_OSR = 6;
   localparam int BIT_MUTE = 3;
   localparam int BIT_DEEMPHASIS_RATE_SELECT_LO = 1;
   localparam int BIT_LEFT = 1;
   localparam int BIT_RIGHT = 0;
   localparam int BIT_SEL_HPL = 2;
   localparam int BIT_SEL_HPR = 4;
   localparam int BIT_SEL_LNL = 6;
   localparam int BIT_SEL_LNR = 8;
   localparam logic [15:0] RST_POWER = 16'h0000;
   localparam logic [15:0] RST_DAC_CTRL = 16'h0008;
   localparam logic [15:0] RST_PATH_CTRL = 16'h0000;
   localparam logic [7:0] GAIN_UNITY = 8'h80;
   localparam logic [7:0] GAIN_STEP = 8'h01;
   localparam int GAIN_SHIFT = 7;
   localparam int COEF_FRAC = 14;

   typedef enum logic [1:0] {
      DACPC_DEEMPHASIS_RATE_SELECT_NONE = 2'h0,
      DACPC_DEEMPHASIS_RATE_SELECT_32K = 2'h1,
      DACPC_DEEMPHASIS_RATE_SELECT_44K1 = 2'h2,
      DACPC_DEEMPHASIS_RATE_SELECT_48K = 2'h3
   } dacpc_deemphasis_rate_select_t;

   typedef enum logic [1:0] {
      DACPC_SRC_DAC = 2'h0,
      DACPC_SRC_BYPASS_L = 2'h1,
      DACPC_SRC_BYPASS_R = 2'h2
   } dacpc_src_t;

   typedef struct packed {
      logic mono;
      logic sloping;
      logic unmute_ramp;
      logic osr_double;
      logic mute;
      dacpc_deemphasis_rate_select_t deemphasis_rate_select;
      logic left_en;
      logic right_en;
   } dacpc_cfg_t;

   typedef struct packed {
      logic signed [15:0] b0;
      logic signed [15:0] a1;
   } dacpc_coef_t;

   // One-pole shelf, unity gain at DC: b0 + a1 equals one in Q14
   function automatic dacpc_coef_t deemphasis_rate_select_coef(input dacpc_deemphasis_rate_select_t rate);
      dacpc_coef_t c;
      c.b0 = 16'sh4000;
      c.a1 = 16'sh0000;
      case (rate)
         DACPC_DEEMPHASIS_RATE_SELECT_32K: begin
            c.b0 = 16'sh2F00;
            c.a1 = 16'sh1100;
         end
         DACPC_DEEMPHASIS_RATE_SELECT_44K1: begin
            c.b0 = 16'sh2B00;
            c.a1 = 16'sh1500;
         end
         DACPC_DEEMPHASIS_RATE_SELECT_48K: begin
            c.b0 = 16'sh2A00;
            c.a1 = 16'sh1600;
         end
         default: begin
            c.b0 = 16'sh4000;
            c.a1 = 16'sh0000;
         end
      endcase
      return c;
   endfunction
endpackage

// file: logic/dacpc_top.sv
// Playback path control: register slave, mono mix, filters, gain ramp, output routing
// Behaviour
// [RULE_01] Mono select bit 12 sums left and right into one mono sample.
// [RULE_02] The mono sum is halved automatically, a 6 dB cut against clipping.
// [RULE_03] Mono with one converter enabled drives that channel only; the other is silent.
// [RULE_04] Both converters enabled means stereo, whatever the mono select bit says.
// [RULE_05] De-emphasis field bits 2:1: none, 32 kHz, 44.1 kHz, 48 kHz.
// [RULE_06] Bit 11 picks the normal or the sloping stopband filter response.
// [RULE_07] Software should pick the sloping filter at sample rates of 24 kHz or below.
// [RULE_08] Bit 6 picks low-power oversampling or doubled high-performance oversampling.
// [RULE_09] Left outputs follow the left converter, right outputs the right one, by default.
// [RULE_10] Each output path has a selector for left or right analogue bypass.
// [RULE_11] Headphone power register: bit 1 enables left, bit 0 enables right.
// [RULE_12] Line output power register: bit 1 enables left, bit 0 enables right.
// [RULE_13] Software enables mid-rail reference and master bias before using the outputs.
// [RULE_14] Software should drive output enables through the sequencer's start-up and shutdown.
// [RULE_15] On unmute, gain ramps back up or jumps back, per the ramp select bit.
// [RULE_16] Mode changes take effect only at a sample boundary.
// [RULE_17] Reset gives stereo, no de-emphasis, normal filter, low-power ratio, outputs off.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module dacpc_top #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic in_valid,
   input wire logic signed [W-1:0] in_left,
   input wire logic signed [W-1:0] in_right,
   output logic out_valid,
   output logic signed [W-1:0] out_left,
   output logic signed [W-1:0] out_right,
   output logic left_converter_enable,
   output logic right_converter_enable,
   output logic oversample_double_select,
   output logic left_headphone_amp_enable,
   output logic right_headphone_amp_enable,
   output logic left_line_amp_enable,
   output logic right_line_amp_enable,
   output logic [1:0] left_headphone_pin_src,
   output logic [1:0] right_headphone_pin_src,
   output logic [1:0] left_line_pin_src,
   output logic [1:0] right_line_pin_src
);
   typedef enum logic [2:0] {
      DACPC_GAIN_HOLD = 3'b001,
      DACPC_GAIN_DOWN = 3'b010,
      DACPC_GAIN_UP = 3'b100
   } dacpc_gain_state_t;

   logic [15:0] hp_pwr_d, hp_pwr_q, line_pwr_d, line_pwr_q;
   logic [15:0] dac_ctrl_d, dac_ctrl_q, path_ctrl_d, path_ctrl_q;
   logic wr_pend_d, wr_pend_q;
   logic [7:0] wr_idx_d, wr_idx_q;
   logic [31:0] hrdata_d, hrdata_q;
   logic addr_phase;
   logic mapped_hi;
   dacpc_pkg::dacpc_cfg_t cfg_reg, act_d, act_q;
   logic mono_eff;
   logic signed [W:0] mono_sum;
   logic s1_valid_d, s1_valid_q;
   logic signed [W-1:0] s1_l_d, s1_l_q, s1_r_d, s1_r_q;
   logic de_valid_l, de_valid_r, ip_valid_l, ip_valid_r;
   logic signed [W-1:0] de_l, de_r, ip_l, ip_r;
   dacpc_gain_state_t gst_d, gst_q;
   logic [7:0] gain_d, gain_q;
   logic out_valid_d, out_valid_q;
   logic signed [W-1:0] out_l_d, out_l_q, out_r_d, out_r_q;

   function automatic logic signed [W-1:0] apply_gain(input logic signed [W-1:0] x, input logic [7:0] g);
      logic signed [W+8:0] p;
      p = (W+9)'(x * $signed({1'b0, g}));
      return W'(p >>> dacpc_pkg::GAIN_SHIFT);
   endfunction

   function automatic logic [31:0] read_reg(input logic [7:0] idx);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (idx)
         dacpc_pkg::IDX_HP_POWER: r = {16'h0000, hp_pwr_q};
         dacpc_pkg::IDX_LINE_POWER: r = {16'h0000, line_pwr_q};
         dacpc_pkg::IDX_DAC_CTRL: r = {16'h0000, dac_ctrl_q};
         dacpc_pkg::IDX_PATH_CTRL: r = {16'h0000, path_ctrl_q};
         dacpc_pkg::IDX_STATUS: r = {16'h0000, 5'h00, gst_q, gain_q};
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   // Bus slave and register file
   always_comb begin
      mapped_hi = (haddr[31:10] == 22'h00_0000);
      addr_phase = hsel && htrans[1] && hready;
      wr_pend_d = addr_phase && hwrite && mapped_hi;
      wr_idx_d = addr_phase ? haddr[9:2] : wr_idx_q;
      hrdata_d = hrdata_q;
      if (addr_phase && !hwrite) begin
         hrdata_d = mapped_hi ? read_reg(haddr[9:2]) : 32'h0000_0000;
      end
      hp_pwr_d = hp_pwr_q;
      line_pwr_d = line_pwr_q;
      dac_ctrl_d = dac_ctrl_q;
      path_ctrl_d = path_ctrl_q;
      if (wr_pend_q) begin
         case (wr_idx_q)
            // RULE_11 headphone enables
            dacpc_pkg::IDX_HP_POWER: hp_pwr_d = {14'h0000, hwdata[1:0]};
            // RULE_12 line enables
            dacpc_pkg::IDX_LINE_POWER: line_pwr_d = {14'h0000, hwdata[1:0]};
            dacpc_pkg::IDX_DAC_CTRL: dac_ctrl_d = hwdata[15:0] & 16'h1A4E;
            dacpc_pkg::IDX_PATH_CTRL: path_ctrl_d = {6'h00, hwdata[9:0]};
            default: dac_ctrl_d = dac_ctrl_q;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
         hp_pwr_q <= dacpc_pkg::RST_POWER;
         line_pwr_q <= dacpc_pkg::RST_POWER;
         dac_ctrl_q <= dacpc_pkg::RST_DAC_CTRL;
         path_ctrl_q <= dacpc_pkg::RST_PATH_CTRL;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_idx_q <= wr_idx_d;
         hrdata_q <= hrdata_d;
         hp_pwr_q <= hp_pwr_d;
         line_pwr_q <= line_pwr_d;
         dac_ctrl_q <= dac_ctrl_d;
         path_ctrl_q <= path_ctrl_d;
      end
   end

   // Mono mix and sample-boundary configuration
   always_comb begin
      cfg_reg.mono = dac_ctrl_q[dacpc_pkg::BIT_MONO];
      cfg_reg.sloping = dac_ctrl_q[dacpc_pkg::BIT_SLOPING];
      cfg_reg.unmute_ramp = dac_ctrl_q[dacpc_pkg::BIT_UNMUTE_RAMP];
      cfg_reg.osr_double = dac_ctrl_q[dacpc_pkg::BIT_OSR];
      cfg_reg.mute = dac_ctrl_q[dacpc_pkg::BIT_MUTE];
      cfg_reg.deemphasis_rate_select = dacpc_pkg::dacpc_deemphasis_rate_select_t'(dac_ctrl_q[dacpc_pkg::BIT_DEEMPHASIS_RATE_SELECT_LO +: 2]);
      cfg_reg.left_en = path_ctrl_q[dacpc_pkg::BIT_LEFT];
      cfg_reg.right_en = path_ctrl_q[dacpc_pkg::BIT_RIGHT];
      // RULE_16 latch settings per sample
      act_d = in_valid ? cfg_reg : act_q;
      // RULE_04 both enabled forces stereo
      mono_eff = cfg_reg.mono && !(cfg_reg.left_en && cfg_reg.right_en);
      // RULE_01 sum both channels
      mono_sum = (W+1)'(in_left) + (W+1)'(in_right);
      s1_valid_d = in_valid;
      s1_l_d = s1_l_q;
      s1_r_d = s1_r_q;
      if (in_valid) begin
         // RULE_02 halve the mono sum
         s1_l_d = mono_eff ? W'(mono_sum >>> 1) : in_left;
         s1_r_d = mono_eff ? W'(mono_sum >>> 1) : in_right;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         // RULE_17 reset configuration
         act_q <= '0;
         s1_valid_q <= 1'b0;
         s1_l_q <= '0;
         s1_r_q <= '0;
      end else begin
         act_q <= act_d;
         s1_valid_q <= s1_valid_d;
         s1_l_q <= s1_l_d;
         s1_r_q <= s1_r_d;
      end
   end

   dacpc_deemphasis_rate_select #(.W(W)) u_deemphasis_rate_select_l (.clk(clk), .rst(rst), .in_valid(s1_valid_q), .in_sample(s1_l_q),
      .rate(act_q.deemphasis_rate_select), .out_valid(de_valid_l), .out_sample(de_l));
   dacpc_deemphasis_rate_select #(.W(W)) u_deemphasis_rate_select_r (.clk(clk), .rst(rst), .in_valid(s1_valid_q), .in_sample(s1_r_q),
      .rate(act_q.deemphasis_rate_select), .out_valid(de_valid_r), .out_sample(de_r));
   dacpc_interp #(.W(W)) u_interp_l (.clk(clk), .rst(rst), .in_valid(de_valid_l), .in_sample(de_l),
      .sloping(act_q.sloping), .out_valid(ip_valid_l), .out_sample(ip_l));
   dacpc_interp #(.W(W)) u_interp_r (.clk(clk), .rst(rst), .in_valid(de_valid_r), .in_sample(de_r),
      .sloping(act_q.sloping), .out_valid(ip_valid_r), .out_sample(ip_r));

   // Soft mute gain and output stage
   always_comb begin
      gst_d = gst_q;
      gain_d = gain_q;
      out_valid_d = ip_valid_l;
      out_l_d = out_l_q;
      out_r_d = out_r_q;
      if (ip_valid_l) begin
         if (act_q.mute) begin
            gst_d = (gain_q > dacpc_pkg::GAIN_STEP) ? DACPC_GAIN_DOWN : DACPC_GAIN_HOLD;
            gain_d = (gain_q > dacpc_pkg::GAIN_STEP) ? gain_q - dacpc_pkg::GAIN_STEP : 8'h00;
         // RULE_15 ramp or instant restore
         end else if (act_q.unmute_ramp && gain_q < dacpc_pkg::GAIN_UNITY) begin
            gst_d = DACPC_GAIN_UP;
            gain_d = gain_q + dacpc_pkg::GAIN_STEP;
         end else begin
            gst_d = DACPC_GAIN_HOLD;
            gain_d = dacpc_pkg::GAIN_UNITY;
         end
         // RULE_03 disabled channel silent
         out_l_d = act_q.left_en ? apply_gain(ip_l, gain_d) : '0;
         out_r_d = act_q.right_en ? apply_gain(ip_r, gain_d) : '0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         gst_q <= DACPC_GAIN_HOLD;
         gain_q <= 8'h00;
         out_valid_q <= 1'b0;
         out_l_q <= '0;
         out_r_q <= '0;
      end else begin
         gst_q <= gst_d;
         gain_q <= gain_d;
         out_valid_q <= out_valid_d;
         out_l_q <= out_l_d;
         out_r_q <= out_r_d;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   assign out_valid = out_valid_q;
   assign out_left = out_l_q;
   assign out_right = out_r_q;
   assign left_converter_enable = act_q.left_en;
   assign right_converter_enable = act_q.right_en;
   // RULE_08 oversampling ratio select
   assign oversample_double_select = act_q.osr_double;
   assign left_headphone_amp_enable = hp_pwr_q[dacpc_pkg::BIT_LEFT];
   assign right_headphone_amp_enable = hp_pwr_q[dacpc_pkg::BIT_RIGHT];
   assign left_line_amp_enable = line_pwr_q[dacpc_pkg::BIT_LEFT];
   assign right_line_amp_enable = line_pwr_q[dacpc_pkg::BIT_RIGHT];
   // RULE_09 RULE_10 per-path source selectors
   assign left_headphone_pin_src = path_ctrl_q[dacpc_pkg::BIT_SEL_HPL +: 2];
   assign right_headphone_pin_src = path_ctrl_q[dacpc_pkg::BIT_SEL_HPR +: 2];
   assign left_line_pin_src = path_ctrl_q[dacpc_pkg::BIT_SEL_LNL +: 2];
   assign right_line_pin_src = path_ctrl_q[dacpc_pkg::BIT_SEL_LNR +: 2];

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_sample_in;
      in_valid ##1 !in_valid [*3];
   endsequence

   chk_silent_channel: assert property ((in_valid && !cfg_reg.right_en) ##0 s_sample_in
      |-> ##1 (out_valid && out_right == '0)) else $error("disabled channel not silent"); // RULE_03
   chk_stereo_force: assert property (in_valid && cfg_reg.left_en && cfg_reg.right_en
      |=> s1_l_q == $past(in_left) && s1_r_q == $past(in_right)) else $error("stereo not forced"); // RULE_04
   chk_mono_atten: assert property (in_valid && mono_eff
      |=> s1_l_q == W'(((W+1)'($past(in_left)) + (W+1)'($past(in_right))) >>> 1)) else $error("mono cut wrong"); // RULE_02
   chk_cfg_boundary: assert property (!in_valid |=> $stable(act_q)) else $error("settings moved mid sample"); // RULE_16
   chk_reset_state: assert property ($fell(rst) |-> act_q == '0 && hp_pwr_q == '0 && line_pwr_q == '0)
      else $error("bad state after reset"); // RULE_17
   chk_instant_unmute: assert property (ip_valid_l && !act_q.mute && !act_q.unmute_ramp
      |=> gain_q == dacpc_pkg::GAIN_UNITY) else $error("instant unmute missed"); // RULE_15
   chk_ramp_step: assert property (ip_valid_l && !act_q.mute && act_q.unmute_ramp && gain_q < dacpc_pkg::GAIN_UNITY
      |=> gain_q == $past(gain_q) + dacpc_pkg::GAIN_STEP) else $error("ramp step wrong"); // RULE_15
   chk_hp_enable: assert property (wr_pend_q && wr_idx_q == dacpc_pkg::IDX_HP_POWER
      |=> left_headphone_amp_enable == $past(hwdata[1]) && right_headphone_amp_enable == $past(hwdata[0]))
      else $error("headphone enable write lost"); // RULE_11
   chk_line_enable: assert property (wr_pend_q && wr_idx_q == dacpc_pkg::IDX_LINE_POWER
      |=> left_line_amp_enable == $past(hwdata[1]) && right_line_amp_enable == $past(hwdata[0]))
      else $error("line enable write lost"); // RULE_12
   chk_deemphasis_rate_select_bypass: assert property (s1_valid_q && act_q.deemphasis_rate_select == dacpc_pkg::DACPC_DEEMPHASIS_RATE_SELECT_NONE
      |=> de_valid_l && de_l == $past(s1_l_q)) else $error("de-emphasis not bypassed"); // RULE_05
endmodule // dacpc_top
